// *** dv/call_file_exec_tb_top.sv ***
// Self-checking bench for the call and file-op executor.
`timescale 1ns/100ps
`default_nettype none
module call_file_exec_tb_top;
  typedef struct {
    exec_pkg::op_t op;
    logic [10:0]   lit;
    logic [7:0]    lat;
    logic          d;
    logic [7:0]    opd;
  } row_t;
  // Each row feeds the model below; zero-accumulator carries d=1 to show d is ignored there.
  row_t rows [10] = '{
    '{exec_pkg::OP_CALL, 11'h7ff, 8'h18, 1'b0, 8'h00},
    '{exec_pkg::OP_INVERT, 11'h000, 8'h00, 1'b0, 8'hff},
    '{exec_pkg::OP_INVERT, 11'h000, 8'h00, 1'b1, 8'h5a},
    '{exec_pkg::OP_ZERO_REG, 11'h000, 8'h00, 1'b0, 8'h33},
    '{exec_pkg::OP_MINUS_ONE, 11'h000, 8'h00, 1'b0, 8'h01},
    '{exec_pkg::OP_ZERO_ACC, 11'h000, 8'h00, 1'b1, 8'h77},
    '{exec_pkg::OP_MINUS_ONE, 11'h000, 8'h00, 1'b1, 8'h00},
    '{exec_pkg::OP_COUNT_DOWN, 11'h000, 8'h00, 1'b1, 8'h01},
    '{exec_pkg::OP_CALL, 11'h000, 8'he7, 1'b0, 8'h00},
    '{exec_pkg::OP_COUNT_DOWN, 11'h000, 8'h00, 1'b0, 8'h05}};
  logic          ref_clk, sys_rst, instr_valid, result_target_bit, instr_ready;
  logic          null_result_flag, reg_write, idle_slot, wr, skip, exp_flag;
  exec_pkg::op_t instr_op;
  logic [10:0]   literal_target;
  logic [6:0]    reg_addr, reg_write_addr;
  logic [7:0]    register_operand, program_counter_latch_high, accumulator_reg, reg_write_data;
  logic [7:0]    exp_acc, res;
  logic [12:0]   instruction_pointer, stack_head, exp_ip, old_ip;
  logic [2:0]    stack_ptr, exp_sp;
  int            failures = 0, checks = 0;
  row_t          r;

  call_file_exec dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_op(instr_op), .literal_target(literal_target), .reg_addr(reg_addr),
    .result_target_bit(result_target_bit), .register_operand(register_operand),
    .program_counter_latch_high(program_counter_latch_high), .instr_ready(instr_ready),
    .instruction_pointer(instruction_pointer), .accumulator_reg(accumulator_reg),
    .null_result_flag(null_result_flag), .reg_write(reg_write),
    .reg_write_addr(reg_write_addr), .reg_write_data(reg_write_data),
    .stack_head(stack_head), .stack_ptr(stack_ptr), .idle_slot(idle_slot));

  // The 40 ns clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Widening to 13 bits keeps unknown bits unknown, so they never match.
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Table loop with a running model, then a refused request, back-to-back ops and a reset.
  initial begin
    {sys_rst, instr_valid, result_target_bit} = 3'h4;
    instr_op = exec_pkg::OP_NONE;
    {literal_target, reg_addr, register_operand, program_counter_latch_high} = '0;
    {exp_ip, exp_acc, exp_flag, exp_sp} = '0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1 chk(instr_ready, 1'b1, "ready after reset");
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr_op <= r.op;
      literal_target <= r.lit;
      program_counter_latch_high <= r.lat;
      result_target_bit <= r.d;
      register_operand <= r.opd;
      reg_addr <= 7'h7f - 7'(i);
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      #1 old_ip = exp_ip;
      skip = 1'b0;
      if (r.op == exec_pkg::OP_CALL) begin
        exp_ip = {r.lat[4:3], r.lit};
        exp_sp = exp_sp + 3'h1;
        chk(stack_head, old_ip + 13'h0001, "return address");
        chk(stack_ptr, exp_sp, "stack count");
        chk(instr_ready, 1'b0, "call second cycle");
      end else begin
        case (r.op)
          exec_pkg::OP_INVERT:                          res = ~r.opd;
          exec_pkg::OP_ZERO_REG, exec_pkg::OP_ZERO_ACC: res = 8'h00;
          default:                                      res = r.opd - 8'h01;
        endcase
        exp_ip = old_ip + 13'h0001;
        wr = (r.op == exec_pkg::OP_ZERO_REG) || (r.d && r.op != exec_pkg::OP_ZERO_ACC);
        skip = (r.op == exec_pkg::OP_COUNT_DOWN) && (res == 8'h00);
        if (!wr) exp_acc = res;
        if (r.op != exec_pkg::OP_COUNT_DOWN) exp_flag = (res == 8'h00);
        chk(reg_write, wr, "write strobe");
        if (wr) chk(reg_write_data, res, "write data");
        if (wr) chk(reg_write_addr, 7'h7f - 7'(i), "write address");
        chk(instr_ready, !skip, "ready after op");
      end
      chk(instruction_pointer, exp_ip, "pointer");
      chk(accumulator_reg, exp_acc, "accumulator");
      chk(null_result_flag, exp_flag, "zero flag");
      chk(idle_slot, skip, "idle slot");
      if (skip) begin
        @(posedge ref_clk);
        #1 exp_ip = exp_ip + 13'h0001;
        chk(instruction_pointer, exp_ip, "pointer after skip");
        chk({idle_slot, instr_ready}, 13'h0001, "skip slot over");
      end
    end
    // A request held through the dead cycle after a call must wait, then run back to back.
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_op <= exec_pkg::OP_CALL;
    literal_target <= 11'h123;
    program_counter_latch_high <= 8'h08;
    @(posedge ref_clk);
    instr_op <= exec_pkg::OP_ZERO_ACC;
    @(posedge ref_clk);
    #1 chk(accumulator_reg, exp_acc, "refused op ran");
    chk(null_result_flag, exp_flag, "call touched flag");
    chk(instruction_pointer, 13'h0923, "call upper bits");
    @(posedge ref_clk);
    instr_op <= exec_pkg::OP_MINUS_ONE;
    result_target_bit <= 1'b0;
    register_operand <= 8'h10;
    #1 chk({accumulator_reg, null_result_flag}, 9'h001, "clear accumulator");
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1 chk({accumulator_reg, null_result_flag}, 9'h01e, "back to back");
    chk(instruction_pointer, 13'h0925, "pointer back to back");
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    #1 chk(instruction_pointer, 13'h0000, "mid-run reset pointer");
    chk(stack_head, 13'h0000, "mid-run reset stack");
    chk({stack_ptr, accumulator_reg, null_result_flag}, 13'h0000, "reset state");
    chk({instr_ready, reg_write, idle_slot}, 13'h0004, "reset strobes");
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // An empty slot taken right after release still steps the pointer.
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_op <= exec_pkg::OP_NONE;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1 chk(instruction_pointer, 13'h0001, "empty slot step");
    chk({reg_write, stack_ptr, accumulator_reg}, 13'h0000, "empty slot quiet");
    end_of_test();
  end
endmodule
`default_nettype wire

// *** verilog/call_file_exec.sv ***
// Executor for subroutine jump and the clear, invert and decrement file operations.
// Summary of operation
// - Call pushes instruction pointer plus one.
// - Call loads 11-bit literal into low pointer.
// - Pointer bits 12:11 from latch bits 4:3.
// - Call takes two cycles, flags unchanged.
// - Invert operand, destination bit picks target.
// - Clear register writes zero, sets zero flag.
// - Decrement operand, destination bit, flag updated.
// - Clear accumulator to zero, set flag.
// - Count down stores result, flags untouched.
// - Zero count-down result skips next instruction, two cycles.
`timescale 1ns/100ps
`default_nettype none
module call_file_exec (
  input  wire logic            ref_clk,
  input  wire logic            sys_rst,
  input  wire logic            instr_valid,
  input  wire exec_pkg::op_t   instr_op,
  input  wire logic [10:0]     literal_target,
  input  wire logic [6:0]      reg_addr,
  input  wire logic            result_target_bit,
  input  wire logic [7:0]      register_operand,
  input  wire logic [7:0]      program_counter_latch_high,
  output logic                 instr_ready,
  output logic      [12:0]     instruction_pointer,
  output logic      [7:0]      accumulator_reg,
  output logic                 null_result_flag,
  output logic                 reg_write,
  output logic      [6:0]      reg_write_addr,
  output logic      [7:0]      reg_write_data,
  output logic      [12:0]     stack_head,
  output logic      [2:0]      stack_ptr,
  output logic                 idle_slot
);
  // Executor state. The pointer holds the address of the instruction being taken,
  // so a call pushes that value plus one. There is no pop path in this block; the
  // return instruction lives next door and reads the stack head directly.
  logic [12:0] ip_q;
  logic [7:0]  acc_q;
  logic        zf_q;
  logic        wr_q;
  logic [6:0]  wa_q;
  logic [7:0]  wd_q;
  logic        busy_q;
  logic        idle_q;

  // Decode of the operation that is taken this cycle.
  wire take        = instr_valid && !busy_q;
  wire is_call     = take && instr_op == exec_pkg::OP_CALL;
  wire is_invert   = take && instr_op == exec_pkg::OP_INVERT;
  wire is_zero_reg = take && instr_op == exec_pkg::OP_ZERO_REG;
  wire is_minus    = take && instr_op == exec_pkg::OP_MINUS_ONE;
  wire is_zero_acc = take && instr_op == exec_pkg::OP_ZERO_ACC;
  wire is_count    = take && instr_op == exec_pkg::OP_COUNT_DOWN;

  // Result of the arithmetic path.
  // A zero operand wraps to ffh, so a decrement of 00h never reports zero.
  wire [7:0] dec_val  = register_operand - exec_pkg::ONE_BYTE;
  wire [7:0] inv_val  = ~register_operand;
  wire [7:0] result   = is_invert ? inv_val :
                        (is_zero_reg || is_zero_acc) ? exec_pkg::ZERO_BYTE : dec_val;
  wire       res_zero = result == exec_pkg::ZERO_BYTE;
  wire       alu_op   = is_invert || is_minus || is_count;
  wire       to_acc   = (alu_op && !result_target_bit) || is_zero_acc;
  wire       to_reg   = (alu_op && result_target_bit) || is_zero_reg;
  // Only these operations touch the zero flag.
  wire       flag_upd = is_invert || is_zero_reg || is_minus || is_zero_acc;
  // A zero count-down result costs one extra idle cycle.
  wire       skip     = is_count && res_zero;

  // Result checks; the zero flag and the skip both hang on the same byte, but no one
  // operation drives both, since count down leaves the flag alone.
  // Invert flag check.
  a_invert_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_invert |=> null_result_flag == (~$past(register_operand) == exec_pkg::ZERO_BYTE))
    else $error("invert zero flag wrong");
  a_count_reg_wb: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_count && result_target_bit |=>
      reg_write && reg_write_data == $past(register_operand) - exec_pkg::ONE_BYTE)
    else $error("count down write-back wrong");
  a_count_acc_wb: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_count && !result_target_bit |=>
      !reg_write && accumulator_reg == $past(register_operand) - exec_pkg::ONE_BYTE)
    else $error("count down accumulator wrong");
  a_no_skip_run: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_count && !res_zero |=> instr_ready && !idle_slot)
    else $error("count down skipped on nonzero");

  wire [12:0] call_target = {program_counter_latch_high[exec_pkg::LATCH_HI:exec_pkg::LATCH_LO],
                             literal_target};
  // Return address is the following instruction.
  wire [12:0] ret_addr    = ip_q + exec_pkg::IP_STEP;

  return_stack u_stack (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .push      (is_call),
    .push_addr (ret_addr),
    .head      (stack_head),
    .depth_ptr (stack_ptr)
  );

  // Stack checks; only a call may move the stack, since nothing here pops.
  // One push per call.
  a_stack_ptr_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_call |=> stack_ptr == $past(stack_ptr) + exec_pkg::SP_STEP)
    else $error("call did not advance stack");
  a_stack_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !is_call |=> $stable(stack_ptr))
    else $error("stack moved without a call");
  a_stack_head_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !is_call |=> $stable(stack_head))
    else $error("stack head moved without a call");

  // Instruction pointer: call loads the target, any other taken op steps.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ip_q <= exec_pkg::IP_RESET;
    end else if (is_call) begin
      ip_q <= call_target;
    end else if (take || idle_q) begin
      ip_q <= ret_addr;
    end
  end

  // Pointer checks; the dead cycle after a call must not step the pointer, or
  // the first instruction of the subroutine would be lost.
  // Taken op steps pointer.
  a_ip_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
    take && !is_call |=>
      instruction_pointer == $past(instruction_pointer) + exec_pkg::IP_STEP)
    else $error("pointer did not step");
  a_ip_hold_call: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !instr_ready && !idle_slot |=> $stable(instruction_pointer))
    else $error("pointer moved in call dead cycle");
  a_idle_ip_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
    idle_slot |=>
      instruction_pointer == $past(instruction_pointer) + exec_pkg::IP_STEP)
    else $error("idle slot did not step pointer");

  // Call and skip hold a second cycle; flags unaffected there.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      busy_q <= is_call || skip;
      idle_q <= skip;
    end
  end

  // A skip shows the idle slot and the stall together for exactly one cycle.
  // A longer stall would starve the fetch side, which cannot hold two words.
  sequence s_skip_slot;
    idle_slot && !instr_ready ##1 !idle_slot && instr_ready;
  endsequence
  a_skip_two_cyc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    skip |=> s_skip_slot)
    else $error("skip slot timing wrong");
  a_ready_returns: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !instr_ready |=> instr_ready)
    else $error("stall lasted more than one cycle");
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    idle_slot |=> !reg_write && !idle_slot)
    else $error("discarded slot did work");
  a_refused_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !instr_ready |=> $stable(accumulator_reg) && $stable(null_result_flag))
    else $error("refused request changed state");

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= exec_pkg::ACC_RESET;
      zf_q  <= 1'b0;
    end else begin
      if (to_acc) begin
        acc_q <= result;
      end
      // Clear ops give zero result, so the flag sets.
      if (flag_upd) begin
        zf_q <= res_zero;
      end
    end
  end

  // Accumulator checks; a call or a write to a register must leave it alone.
  // Call leaves data alone.
  a_call_acc_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_call |=> !reg_write && $stable(accumulator_reg))
    else $error("call touched data path");
  a_zero_acc_nowr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_zero_acc |=> !reg_write)
    else $error("clear accumulator wrote a register");
  a_invert_reg_wb: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_invert && result_target_bit |=>
      reg_write && reg_write_data == ~$past(register_operand) && $stable(accumulator_reg))
    else $error("invert write-back wrong");
  a_flag_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !flag_upd |=> $stable(null_result_flag))
    else $error("zero flag changed without update");

  // Register write-back port, one cycle per operation.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= 1'b0;
      wa_q <= 7'h00;
      wd_q <= exec_pkg::ZERO_BYTE;
    end else begin
      wr_q <= to_reg;
      wa_q <= reg_addr;
      wd_q <= result;
    end
  end

  // Write-back checks; the address is registered beside the data so both land together.
  // Decrement to accumulator.
  a_minus_acc_wb: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_minus && !result_target_bit |=>
      !reg_write && accumulator_reg == $past(register_operand) - exec_pkg::ONE_BYTE)
    else $error("decrement to accumulator wrong");
  a_zero_reg_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_zero_reg |=> reg_write_addr == $past(reg_addr) && $stable(accumulator_reg))
    else $error("clear register address wrong");
  a_wb_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    to_reg |=> reg_write && reg_write_addr == $past(reg_addr))
    else $error("write-back address wrong");
  a_write_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !to_reg |=> !reg_write)
    else $error("stray register write");

  // Outputs; ready drops only after call or skip.
  assign instr_ready         = !busy_q;
  assign instruction_pointer = ip_q;
  assign accumulator_reg     = acc_q;
  assign null_result_flag    = zf_q;
  assign reg_write           = wr_q;
  assign reg_write_addr      = wa_q;
  assign reg_write_data      = wd_q;
  assign idle_slot           = idle_q;

  // Checks.
  a_call_push_ret: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_call |=> stack_head == $past(ip_q) + exec_pkg::IP_STEP)
    else $error("call did not push return address");
  a_call_low_bits: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_call |=> ip_q[10:0] == $past(literal_target))
    else $error("call target low bits wrong");
  a_call_high_bits: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_call |=> ip_q[12:11] == $past(program_counter_latch_high[4:3]))
    else $error("call target high bits wrong");
  sequence s_call_busy;
    !instr_ready ##1 instr_ready;
  endsequence
  a_call_two_cyc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_call |=> s_call_busy and $stable(zf_q))
    else $error("call timing or flag wrong");
  a_invert_acc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_invert && !result_target_bit |=> acc_q == ~$past(register_operand))
    else $error("invert to accumulator wrong");
  a_zero_reg_w: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_zero_reg |=> wr_q && wd_q == 8'h00 && zf_q)
    else $error("clear register wrong");
  a_minus_reg: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_minus && result_target_bit |=> wr_q && wd_q == $past(register_operand) - 8'h01)
    else $error("decrement write-back wrong");
  a_zero_acc_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_zero_acc |=> acc_q == 8'h00 && zf_q)
    else $error("clear accumulator wrong");
  a_count_flags: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_count |=> $stable(zf_q))
    else $error("count down altered flag");
  a_skip_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_count |=> idle_slot == ($past(register_operand) == 8'h01))
    else $error("skip idle slot wrong");
  a_flag_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_minus |=> zf_q == ($past(register_operand) == 8'h01))
    else $error("zero flag wrong");
  a_single_cyc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (is_invert || is_minus || is_zero_reg || is_zero_acc) |=> instr_ready)
    else $error("single cycle op stalled");
endmodule
`default_nettype wire

// *** verilog/exec_pkg.sv ***
// Package with opcodes, widths and reset values for the call and file-op executor.
`default_nettype none
package exec_pkg;
  localparam int IP_W         = 13;
  localparam int LIT_W        = 11;
  localparam int ADDR_W       = 7;
  localparam int DATA_W       = 8;
  localparam int LATCH_LO     = 3;
  localparam int LATCH_HI     = 4;
  localparam int STACK_DEPTH  = 8;
  localparam int SP_W         = 3;
  localparam logic [12:0] IP_RESET  = 13'h0000;
  localparam logic [7:0]  ACC_RESET = 8'h00;
  localparam logic [7:0]  ZERO_BYTE = 8'h00;
  localparam logic [7:0]  ONE_BYTE  = 8'h01;
  localparam logic [12:0] IP_STEP   = 13'h0001;
  localparam logic [2:0]  SP_RESET  = 3'h0;
  localparam logic [2:0]  SP_STEP   = 3'h1;
  typedef enum logic [2:0] {
    OP_NONE, OP_CALL, OP_INVERT, OP_ZERO_REG, OP_MINUS_ONE, OP_ZERO_ACC, OP_COUNT_DOWN
  } op_t;
endpackage
`default_nettype wire

// *** verilog/return_stack.sv ***
// Hardware return stack for the executor, flip-flop storage with wrapping pointer.
`timescale 1ns/100ps
`default_nettype none
module return_stack (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        push,
  input  wire logic [12:0] push_addr,
  output logic      [12:0] head,
  output logic      [2:0]  depth_ptr
);
  logic [12:0] slot_q [exec_pkg::STACK_DEPTH];
  logic [2:0]  ptr_q;

  // The pointer wraps silently, so an overflow overwrites the oldest entry.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q <= exec_pkg::SP_RESET;
    end else if (push) begin
      ptr_q <= ptr_q + exec_pkg::SP_STEP;
    end
  end

  // One storage slot per entry, written only when the pointer selects it.
  genvar i;
  generate
    for (i = 0; i < exec_pkg::STACK_DEPTH; i++) begin : g_slot
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          slot_q[i] <= exec_pkg::IP_RESET;
        end else if (push && ptr_q == 3'(i)) begin
          slot_q[i] <= push_addr;
        end
      end
    end
  endgenerate

  // The head is the most recently pushed entry.
  assign head      = slot_q[ptr_q - exec_pkg::SP_STEP];
  assign depth_ptr = ptr_q;
endmodule
`default_nettype wire
